//--- verilog/jtag_tap_target.sv
// Boundary scan port of the memory device, on the system clock.
`timescale 1ns/1ps
module jtag_tap_target #(
	parameter int          BSR_LEN = jtag_tap_pkg::RING_LEN,
	// Arbitrary identification value.
	parameter logic [31:0] ID_CODE = 32'h1a2b_3c4d
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_resetn,
	jtag_link_if.target             link,
	input  wire logic [BSR_LEN-1:0] i_ring,
	output logic      [BSR_LEN-1:0] o_ring_drive,
	output logic                    o_extest,
	output logic                    o_q_hiz,
	output logic      [2:0]         o_instr
);

	// ==========================================================
	// Pin synchronisers
	logic [2:0] sync_tck;
	logic [2:0] sync_tms;
	logic [2:0] sync_tdi;
	logic       tck_lvl;
	logic       tms_lvl;
	logic       tdi_lvl;
	logic       tck_rise;
	logic       tck_fall;

	always_ff @(posedge i_sys_clk) begin
		sync_tck <= {sync_tck[1:0], link.tck};
		sync_tms <= {sync_tms[1:0], link.tms};
		sync_tdi <= {sync_tdi[1:0], link.tdi};
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			tck_lvl <= 1'b0;
			tms_lvl <= 1'b1;
			tdi_lvl <= 1'b1;
		end else begin
			if (sync_tck[1] == sync_tck[2])
				tck_lvl <= sync_tck[2];
			if (sync_tms[1] == sync_tms[2])
				tms_lvl <= sync_tms[2];
			if (sync_tdi[1] == sync_tdi[2])
				tdi_lvl <= sync_tdi[2];
		end
	end

	assign tck_rise = sync_tck[1] & sync_tck[2] & ~tck_lvl;
	assign tck_fall = ~sync_tck[1] & ~sync_tck[2] & tck_lvl;

	// ==========================================================
	// Controller
	jtag_tap_pkg::tap_state_t state;

	function automatic jtag_tap_pkg::tap_state_t step(
		input jtag_tap_pkg::tap_state_t s, input logic m);
		case (s)
		jtag_tap_pkg::TAP_RESET: step = m ? jtag_tap_pkg::TAP_RESET
			: jtag_tap_pkg::TAP_IDLE;
		jtag_tap_pkg::TAP_IDLE: step = m ? jtag_tap_pkg::TAP_SEL_DR
			: jtag_tap_pkg::TAP_IDLE;
		jtag_tap_pkg::TAP_SEL_DR: step = m ? jtag_tap_pkg::TAP_SEL_IR
			: jtag_tap_pkg::TAP_CAPTURE_DR;
		jtag_tap_pkg::TAP_CAPTURE_DR, jtag_tap_pkg::TAP_SHIFT_DR:
			step = m ? jtag_tap_pkg::TAP_EXIT1_DR
			: jtag_tap_pkg::TAP_SHIFT_DR;
		jtag_tap_pkg::TAP_EXIT1_DR: step = m ? jtag_tap_pkg::TAP_UPDATE_DR
			: jtag_tap_pkg::TAP_PAUSE_DR;
		jtag_tap_pkg::TAP_PAUSE_DR: step = m ? jtag_tap_pkg::TAP_EXIT2_DR
			: jtag_tap_pkg::TAP_PAUSE_DR;
		jtag_tap_pkg::TAP_EXIT2_DR: step = m ? jtag_tap_pkg::TAP_UPDATE_DR
			: jtag_tap_pkg::TAP_SHIFT_DR;
		jtag_tap_pkg::TAP_UPDATE_DR, jtag_tap_pkg::TAP_UPDATE_IR:
			step = m ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
		jtag_tap_pkg::TAP_SEL_IR: step = m ? jtag_tap_pkg::TAP_RESET
			: jtag_tap_pkg::TAP_CAPTURE_IR;
		jtag_tap_pkg::TAP_CAPTURE_IR, jtag_tap_pkg::TAP_SHIFT_IR:
			step = m ? jtag_tap_pkg::TAP_EXIT1_IR
			: jtag_tap_pkg::TAP_SHIFT_IR;
		jtag_tap_pkg::TAP_EXIT1_IR: step = m ? jtag_tap_pkg::TAP_UPDATE_IR
			: jtag_tap_pkg::TAP_PAUSE_IR;
		jtag_tap_pkg::TAP_PAUSE_IR: step = m ? jtag_tap_pkg::TAP_EXIT2_IR
			: jtag_tap_pkg::TAP_PAUSE_IR;
		jtag_tap_pkg::TAP_EXIT2_IR: step = m ? jtag_tap_pkg::TAP_UPDATE_IR
			: jtag_tap_pkg::TAP_SHIFT_IR;
		default: step = jtag_tap_pkg::TAP_RESET;
		endcase
	endfunction

	// Reserved codes fall back to the bypass path so the chain stays short.
	function automatic jtag_tap_pkg::dr_path_t path_of(input logic [2:0] c);
		case (c)
		jtag_tap_pkg::INSTR_IDENTIFY: path_of = jtag_tap_pkg::PATH_IDENT;
		jtag_tap_pkg::INSTR_EXTEST,
		jtag_tap_pkg::INSTR_SAMPLE,
		jtag_tap_pkg::INSTR_SAMPLE_Z: path_of = jtag_tap_pkg::PATH_RING;
		default: path_of = jtag_tap_pkg::PATH_BYPASS;
		endcase
	endfunction

	// state stepping; five high samples reach reset; power-up
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn)
			state <= jtag_tap_pkg::TAP_RESET;
		else if (tck_rise)
			state <= step(state, tms_lvl);
	end

	// ==========================================================
	// Instruction register
	logic [2:0]             instr;
	logic [2:0]             ir_sr;
	jtag_tap_pkg::dr_path_t path;

	assign path = path_of(instr);

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			instr <= jtag_tap_pkg::INSTR_IDENTIFY;
			ir_sr <= jtag_tap_pkg::IR_CAPTURE_VAL;
		end else if (tck_rise) begin
			if (step(state, tms_lvl) == jtag_tap_pkg::TAP_RESET)
				instr <= jtag_tap_pkg::INSTR_IDENTIFY;
			case (state)
			jtag_tap_pkg::TAP_RESET: instr <= jtag_tap_pkg::INSTR_IDENTIFY;
			jtag_tap_pkg::TAP_CAPTURE_IR: ir_sr <= jtag_tap_pkg::IR_CAPTURE_VAL;
			jtag_tap_pkg::TAP_SHIFT_IR: ir_sr <= {tdi_lvl, ir_sr[2:1]};
			jtag_tap_pkg::TAP_UPDATE_IR: instr <= ir_sr;
			default: ir_sr <= ir_sr;
			endcase
		end
	end

	// ==========================================================
	// Data registers
	logic               byp;
	logic [31:0]        id_sr;
	logic [BSR_LEN-1:0] bsr_sr;
	logic [BSR_LEN-1:0] preload;
	logic [BSR_LEN-1:0] preload_rst;

	always_comb begin
		preload_rst = '0;
		preload_rst[jtag_tap_pkg::RING_OE_BIT] = 1'b1;
	end

	// only the path of the held instruction moves
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			byp    <= 1'b0;
			id_sr  <= '0;
			bsr_sr <= '0;
		end else if (tck_rise) begin
			if (state == jtag_tap_pkg::TAP_CAPTURE_DR) begin
				case (path)
				jtag_tap_pkg::PATH_BYPASS: byp <= 1'b0;
				jtag_tap_pkg::PATH_IDENT: id_sr <= ID_CODE;
				default: bsr_sr <= i_ring;
				endcase
			end else if (state == jtag_tap_pkg::TAP_SHIFT_DR) begin
				case (path)
				jtag_tap_pkg::PATH_BYPASS: byp <= tdi_lvl;
				jtag_tap_pkg::PATH_IDENT: id_sr <= {tdi_lvl, id_sr[31:1]};
				default: bsr_sr <= {tdi_lvl, bsr_sr[BSR_LEN-1:1]};
				endcase
			end
		end
	end

	// the preload latches load under sample or extest and feed o_ring_drive in every mode.
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn)
			preload <= preload_rst;
		else if (tck_rise) begin
			if (state == jtag_tap_pkg::TAP_RESET ||
				step(state, tms_lvl) == jtag_tap_pkg::TAP_RESET)
				preload <= preload_rst;
			else if (state == jtag_tap_pkg::TAP_UPDATE_DR &&
				(instr == jtag_tap_pkg::INSTR_SAMPLE ||
				instr == jtag_tap_pkg::INSTR_EXTEST))
				preload <= bsr_sr;
		end
	end

	// ==========================================================
	// Serial output, changed on the falling test clock edge
	logic tdo_q;
	logic tdo_oe_n_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			tdo_q      <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n_q <= !(state == jtag_tap_pkg::TAP_SHIFT_IR ||
				state == jtag_tap_pkg::TAP_SHIFT_DR);
			if (state == jtag_tap_pkg::TAP_SHIFT_IR)
				tdo_q <= ir_sr[0];
			else if (path == jtag_tap_pkg::PATH_BYPASS)
				tdo_q <= byp;
			else if (path == jtag_tap_pkg::PATH_IDENT)
				tdo_q <= id_sr[0];
			else
				tdo_q <= bsr_sr[0];
		end
	end

	assign link.tdo_drv  = tdo_q;
	assign link.tdo_oe_n = tdo_oe_n_q;

	// ==========================================================
	// Memory-side controls
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_ring_drive <= '0;
			o_extest     <= 1'b0;
			o_q_hiz      <= 1'b0;
			o_instr      <= jtag_tap_pkg::INSTR_IDENTIFY;
		end else begin
			o_ring_drive <= preload;
			o_extest     <= instr == jtag_tap_pkg::INSTR_EXTEST;
			o_instr      <= instr;
			// float under sample-float until a new update
			o_q_hiz <= instr == jtag_tap_pkg::INSTR_SAMPLE_Z ||
				(instr == jtag_tap_pkg::INSTR_EXTEST &&
				!preload[jtag_tap_pkg::RING_OE_BIT]);
		end
	end

endmodule

//--- verilog/jtag_tap_pkg.sv
// Shared constants and types for the boundary scan port and its tester.
package jtag_tap_pkg;

	// ==========================================================
	// Controller states
	typedef enum logic [3:0] {
		TAP_RESET      = 4'h0,
		TAP_IDLE       = 4'h1,
		TAP_SEL_DR     = 4'h2,
		TAP_CAPTURE_DR = 4'h3,
		TAP_SHIFT_DR   = 4'h4,
		TAP_EXIT1_DR   = 4'h5,
		TAP_PAUSE_DR   = 4'h6,
		TAP_EXIT2_DR   = 4'h7,
		TAP_UPDATE_DR  = 4'h8,
		TAP_SEL_IR     = 4'h9,
		TAP_CAPTURE_IR = 4'ha,
		TAP_SHIFT_IR   = 4'hb,
		TAP_EXIT1_IR   = 4'hc,
		TAP_PAUSE_IR   = 4'hd,
		TAP_EXIT2_IR   = 4'he,
		TAP_UPDATE_IR  = 4'hf
	} tap_state_t;

	// ==========================================================
	// Instructions
	localparam int IR_LEN = 3;
	typedef enum logic [2:0] {
		INSTR_EXTEST   = 3'h0,
		INSTR_IDENTIFY = 3'h1,
		INSTR_SAMPLE_Z = 3'h2,
		INSTR_RSVD_A   = 3'h3,
		INSTR_SAMPLE   = 3'h4,
		INSTR_RSVD_B   = 3'h5,
		INSTR_RSVD_C   = 3'h6,
		INSTR_BYPASS   = 3'h7
	} instr_t;
	localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

	typedef enum logic [1:0] {
		PATH_BYPASS = 2'h0,
		PATH_IDENT  = 2'h1,
		PATH_RING   = 2'h2
	} dr_path_t;

	// ==========================================================
	// Scan chain layout
	localparam int ID_LEN         = 32;
	localparam int RING_LEN       = 48;
	localparam int RING_OE_BIT    = 47;
	localparam int RESET_TMS_HIGH = 5;

	// ==========================================================
	// Tester registers, byte addresses on the bus
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_LEN    = 8'h04;
	localparam logic [7:0] REG_TXD    = 8'h08;
	localparam logic [7:0] REG_RXD    = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_IR_BIT    = 1;
	localparam int CTRL_RESET_BIT = 2;
	localparam int TCK_HALF_CYC   = 6;
	localparam logic [4:0] LEN_RESET = 5'h00;

endpackage

//--- verilog/jtag_link_if.sv
// Four-wire test link between the tester and the scanned device.
`timescale 1ns/1ps
interface jtag_link_if;
	logic tck;
	logic tms_drv;
	logic tms_oe_n;
	logic tdi_drv;
	logic tdi_oe_n;
	logic tdo_drv;
	logic tdo_oe_n;
	logic tms;
	logic tdi;
	logic tdo;

	// Released pins read high through the pull-ups.
	assign tms = tms_oe_n ? 1'b1 : tms_drv;
	assign tdi = tdi_oe_n ? 1'b1 : tdi_drv;
	assign tdo = tdo_oe_n ? 1'b1 : tdo_drv;

	modport tester (output tck, tms_drv, tms_oe_n, tdi_drv, tdi_oe_n,
		input tdo, tdo_oe_n);
	modport target (input tck, tms, tdi, output tdo_drv, tdo_oe_n);
endinterface

//--- verilog/jtag_tap_tester.sv
// Scan tester end: bus-controlled sequencer that drives the test link.
`timescale 1ns/1ps
module jtag_tap_tester #(
	parameter int TCK_HALF = jtag_tap_pkg::TCK_HALF_CYC
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	jtag_link_if.tester      link,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp
);

	// ==========================================================
	// Bus slave and command registers
	logic [7:0]  addr_q;
	logic        wr_pend;
	logic        rd_pend;
	logic [4:0]  len_m1;
	logic [31:0] txd;
	logic [31:0] rxd;
	logic        op_ir;
	logic        op_reset;
	logic        go;
	logic        busy;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			addr_q      <= '0;
			wr_pend     <= 1'b0;
			rd_pend     <= 1'b0;
			o_hreadyout <= 1'b1;
			o_hrdata    <= '0;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			if (i_hsel && i_htrans[1] && i_hready) begin
				addr_q  <= i_haddr[7:0];
				wr_pend <= i_hwrite;
				rd_pend <= !i_hwrite;
				if (!i_hwrite)
					o_hreadyout <= 1'b0;
			end
			if (rd_pend) begin
				o_hreadyout <= 1'b1;
				case (addr_q)
				jtag_tap_pkg::REG_CTRL:   o_hrdata <= {29'h0, op_reset, op_ir, busy};
				jtag_tap_pkg::REG_LEN:    o_hrdata <= {27'h0, len_m1};
				jtag_tap_pkg::REG_TXD:    o_hrdata <= txd;
				jtag_tap_pkg::REG_RXD:    o_hrdata <= rxd;
				jtag_tap_pkg::REG_STATUS: o_hrdata <= {31'h0, busy};
				default:                  o_hrdata <= '0;
				endcase
			end
		end
	end

	// Commands written while a scan runs are dropped, not queued.
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			len_m1   <= jtag_tap_pkg::LEN_RESET;
			txd      <= '0;
			op_ir    <= 1'b0;
			op_reset <= 1'b0;
			go       <= 1'b0;
		end else begin
			go <= 1'b0;
			if (wr_pend && !busy && !go) begin
				case (addr_q)
				jtag_tap_pkg::REG_CTRL: begin
					op_ir    <= i_hwdata[jtag_tap_pkg::CTRL_IR_BIT];
					op_reset <= i_hwdata[jtag_tap_pkg::CTRL_RESET_BIT];
					go       <= i_hwdata[jtag_tap_pkg::CTRL_START_BIT];
				end
				jtag_tap_pkg::REG_LEN: len_m1 <= i_hwdata[4:0];
				jtag_tap_pkg::REG_TXD: txd <= i_hwdata;
				default: txd <= txd;
				endcase
			end
		end
	end

	// ==========================================================
	// Bit sequence: mode select and data for link step k
	logic [6:0] k;
	logic [6:0] pre;
	logic [6:0] last;
	logic [6:0] total;
	logic [6:0] idx;
	logic       bit_tms;
	logic       bit_tdi;
	logic       bit_shift;

	always_comb begin
		pre       = op_ir ? 7'd4 : 7'd3;
		last      = pre + {2'b00, len_m1} + 7'd1;
		idx       = k - pre;
		bit_tdi   = 1'b1;
		bit_shift = 1'b0;
		if (op_reset) begin
			// five high, then one low to idle
			total   = 7'(jtag_tap_pkg::RESET_TMS_HIGH + 1);
			bit_tms = k < 7'(jtag_tap_pkg::RESET_TMS_HIGH);
		end else begin
			total = last + 7'd2;
			if (k < pre)
				bit_tms = k < pre - 7'd2;
			else if (k < last) begin
				bit_tms   = k == last - 7'd1;
				bit_tdi   = txd[idx[4:0]];
				bit_shift = 1'b1;
			end else
				bit_tms = k == last;
		end
	end

	// ==========================================================
	// Link engine, clock made by dividing the system clock
	logic [2:0] sync_tdo;
	logic       tdo_lvl;
	logic [7:0] cnt;
	logic       cap_pend;
	logic [4:0] cap_idx;
	logic       tck_q;
	logic       tms_q;
	logic       tdi_q;

	always_ff @(posedge i_sys_clk)
		sync_tdo <= {sync_tdo[1:0], link.tdo};

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn)
			tdo_lvl <= 1'b1;
		else if (sync_tdo[1] == sync_tdo[2])
			tdo_lvl <= sync_tdo[2];
	end

	// Data is read late in the high phase, which leaves room for both
	// synchronisers; the divider must stay at least this slow.
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			busy     <= 1'b0;
			k        <= '0;
			cnt      <= '0;
			cap_pend <= 1'b0;
			cap_idx  <= '0;
			rxd      <= '0;
			tck_q    <= 1'b0;
			tms_q    <= 1'b1;
			tdi_q    <= 1'b1;
		end else if (go) begin
			busy     <= 1'b1;
			cnt      <= '0;
			tms_q    <= bit_tms;
			tdi_q    <= bit_tdi;
			cap_pend <= bit_shift;
			cap_idx  <= idx[4:0];
			k        <= k + 7'd1;
		end else if (busy) begin
			cnt <= cnt + 8'd1;
			if (cnt == 8'(TCK_HALF - 1)) begin
				cnt   <= '0;
				tck_q <= !tck_q;
				if (tck_q) begin
					if (cap_pend)
						rxd[cap_idx] <= tdo_lvl;
					cap_pend <= bit_shift && k != total;
					cap_idx  <= idx[4:0];
					if (k == total) begin
						busy <= 1'b0;
						k    <= '0;
					end else begin
						tms_q <= bit_tms;
						tdi_q <= bit_tdi;
						k     <= k + 7'd1;
					end
				end
			end
		end
	end

	// idle clock low, pins released to pull-ups
	assign link.tck      = tck_q;
	assign link.tms_drv  = tms_q;
	assign link.tdi_drv  = tdi_q;
	assign link.tms_oe_n = !busy;
	assign link.tdi_oe_n = !busy;

endmodule

//--- verif/jtag_tap_asserts.sv
// Concurrent checks on the test link between tester and target.
`timescale 1ns/1ps
module jtag_tap_asserts #(
	parameter int TCK_HALF = jtag_tap_pkg::TCK_HALF_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic tck,
	input wire logic tms_drv,
	input wire logic tms_oe_n,
	input wire logic tdi_drv,
	input wire logic tdo_drv,
	input wire logic tdo_oe_n
);
	// ==========================================================
	// Length of the high phase, counted on the system clock
	logic [7:0] high_cnt;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || !tck) begin
			high_cnt <= 8'h00;
		end else begin
			high_cnt <= high_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	// ==========================================================
	// Link timing
	a_tdo_on_fall: assert property (
		$changed(tdo_drv) |-> !tck)
		else $error("serial out moved while clock high");
	a_oe_on_fall: assert property (
		$changed(tdo_oe_n) |-> !tck)
		else $error("serial out enable moved while clock high");
	a_inputs_on_fall: assert property (
		($changed(tms_drv) || $changed(tdi_drv)) |-> !tck)
		else $error("mode or data moved while clock high");
	a_high_length: assert property (
		$fell(tck) |-> high_cnt == 8'(TCK_HALF))
		else $error("clock high phase has wrong length");
	a_low_length: assert property (
		$fell(tck) |-> !tck [*6])
		else $error("clock low phase too short");
	a_idle_clock_low: assert property (
		tms_oe_n |-> !tck)
		else $error("clock runs while tester idle");
	a_drive_in_scan: assert property (
		!tdo_oe_n |-> !tms_oe_n)
		else $error("serial out driven outside a scan");
	a_power_up_float: assert property (
		$rose(i_resetn) |-> tdo_oe_n ##1 tdo_oe_n)
		else $error("serial out driven after reset");
endmodule

//--- verif/testbench.sv
// Self-checking bench: bus-driven tester scanning the target port.
`timescale 1ns/1ps
module testbench;
	// Arbitrary identification value.
	localparam logic [31:0] ID_VAL = 32'h1a2b_3c4d;
	localparam int          CEIL   = 20000;
	localparam logic [2:0]  CODES [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
	logic        i_sys_clk;
	logic        i_resetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [47:0] ring;
	logic [47:0] ring_drive;
	logic        extest;
	logic        q_hiz;
	logic [2:0]  instr;
	int          failures;
	int          checked;
	int          cycles;

	jtag_link_if link();
	jtag_tap_tester u_jtag_tap_tester (.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn), .link(link), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp));
	jtag_tap_target #(.ID_CODE(ID_VAL)) u_jtag_tap_target (
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .link(link),
		.i_ring(ring), .o_ring_drive(ring_drive), .o_extest(extest),
		.o_q_hiz(q_hiz), .o_instr(instr));
	jtag_tap_asserts u_jtag_tap_asserts (.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn), .tck(link.tck), .tms_drv(link.tms_drv),
		.tms_oe_n(link.tms_oe_n), .tdi_drv(link.tdi_drv),
		.tdo_drv(link.tdo_drv), .tdo_oe_n(link.tdo_oe_n));

	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	// ==========================================================
	// Reporting
	task results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == CEIL) begin
			failures++;
			results();
		end
	end

	// ==========================================================
	// Bus and scan tasks
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge i_sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge i_sys_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	// Polls busy; the bench timeout ends a scan that never finishes.
	task start_wait(input logic [31:0] ctrl);
		logic [31:0] r;
		xfer(1'b1, jtag_tap_pkg::REG_CTRL, ctrl, r);
		do xfer(1'b0, jtag_tap_pkg::REG_STATUS, 32'h0, r);
		while (r[0] !== 1'b0);
	endtask

	task scan(input logic ir, input int n, input logic [31:0] tx,
		output logic [31:0] rx);
		logic [31:0] r;
		xfer(1'b1, jtag_tap_pkg::REG_LEN, 32'(n - 1), r);
		xfer(1'b1, jtag_tap_pkg::REG_TXD, tx, r);
		start_wait(ir ? 32'h3 : 32'h1);
		xfer(1'b0, jtag_tap_pkg::REG_RXD, 32'h0, rx);
	endtask

	function automatic logic [31:0] exp_rx(input logic [2:0] c,
		input logic [31:0] t);
		case (c)
			3'h1: exp_rx = ID_VAL;
			3'h7: exp_rx = {t[30:0], 1'b0};
			default: exp_rx = ring[31:0];
		endcase
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] rx;
		logic [31:0] tx;
		failures = 0;
		checked = 0;
		cycles = 0;
		i_resetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		ring = '0;
		void'($urandom(32'h68e39122));
		repeat (12) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		ring <= 48'({$urandom, $urandom});
		@(posedge i_sys_clk);
		check(32'(instr), 32'h1);
		check(32'(link.tdo_oe_n), 32'h1);
		xfer(1'b0, 8'h20, 32'h0, rx);
		check(rx, 32'h0);
		check(32'(hresp), 32'h0);
		foreach (CODES[i]) begin
			start_wait(32'h5);
			check(32'(instr), 32'h1);
			scan(1'b1, 3, 32'(CODES[i]), rx);
			check(32'(rx[2:0]), 32'h1);
			check(32'(instr), 32'(CODES[i]));
			check(32'(q_hiz), 32'(CODES[i] == 3'h2));
			check(32'(extest), 32'(CODES[i] == 3'h0));
			tx = $urandom;
			scan(1'b0, 32, tx, rx);
			check(rx, exp_rx(CODES[i], tx));
		end
		// A preloaded zero in the tri-state cell floats the bus under extest.
		start_wait(32'h5);
		scan(1'b1, 3, 32'h4, rx);
		tx = $urandom & 32'h7fff_ffff;
		scan(1'b0, 32, tx, rx);
		check(ring_drive[47:16], tx);
		scan(1'b1, 3, 32'h0, rx);
		check(32'({extest, q_hiz}), 32'h3);
		start_wait(32'h5);
		check(32'({instr, q_hiz}), 32'h2);
		xfer(1'b0, jtag_tap_pkg::REG_CTRL, 32'h0, rx);
		check(rx, 32'h4);
		xfer(1'b0, jtag_tap_pkg::REG_LEN, 32'h0, rx);
		check(rx, 32'h2);
		results();
	end
endmodule
